// *** overcurrent_fault_response.sv ***
// paged over-current fault response register and fault status logic
// Contract
// - on over-current set summary and over-current bits in status word
// - on over-current set current fault and current warning bits
// - on over-current assert the alert line
// - bits 2:0 fixed at 111, seven soft-start units of retry delay
// - page 0 always writable; page 1 only when channel two is master
// - page 1 write to slave channel is refused, flagged invalid command, alerts
// - response register resets to 00000111
// - bits 7:6 ignore writes and read zero
// - retry 000 keeps output off until fault cleared
// - retry 111 restarts endlessly until off, bias loss or other fault
// - other retry values refused, set cml and invalid data, alert
// - on over-current also set over-current bit in status byte
`include "ocfr_defines.svh"
module overcurrent_fault_response (
    input  wire logic       CORE_CLK,
    input  wire logic       RST_B,
    input  wire logic       WR_STROBE,
    input  wire logic       RD_STROBE,
    input  wire logic [1:0] PAGE,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       CH2_MASTER,
    input  wire logic [1:0] OC_FAULT_IN,
    input  wire logic [1:0] UV_FAULT_IN,
    input  wire logic [1:0] CMD_ON,
    input  wire logic       BIAS_OK,
    input  wire logic [1:0] OTHER_FAULT,
    input  wire logic [1:0] SS_DONE,
    input  wire logic       CLEAR_FAULTS,
    output logic [7:0]      RD_DATA,
    output logic            WR_NACK,
    output logic            ALERT_LINE_B,
    output logic [7:0]      CH1_STATUS,
    output logic [7:0]      CH2_STATUS,
    output logic [1:0]      OUT_ENABLE,
    output logic [1:0]      SOFT_START
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // detector and control pins come from the converter domain
    logic [5:0] pins_meta_q, pins_sync_q, pins_prev_q;
    logic [5:0] pins_raw;
    logic [1:0] oc_rise, uv_rise;

    assign pins_raw = {OC_FAULT_IN, UV_FAULT_IN, CMD_ON};

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            pins_meta_q <= '0;
            pins_sync_q <= '0;
            pins_prev_q <= '0;
        end else begin
            pins_meta_q <= pins_raw;
            pins_sync_q <= pins_meta_q;
            pins_prev_q <= pins_sync_q;
        end
    end

    // fault detectors are level; only the rising edge starts a response
    assign oc_rise = pins_sync_q[5:4] & ~pins_prev_q[5:4];
    assign uv_rise = pins_sync_q[3:2] & ~pins_prev_q[3:2];

    logic [1:0] bias_meta_q, bias_sync_q;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            bias_meta_q <= '0;
            bias_sync_q <= '0;
        end else begin
            bias_meta_q <= {BIAS_OK, CLEAR_FAULTS};
            bias_sync_q <= bias_meta_q;
        end
    end

    // ----------------------------------------
    // response register and write checks
    // ----------------------------------------
    logic [2:0]  retry1_q, retry1_d, retry2_q, retry2_d;
    logic [7:0]  rd_data_d;
    logic        nack_d;
    logic        wr_ch1, wr_ch2, bad_page, bad_data;
    logic [2:0]  retry_in;
    logic [2:0]  retry2_eff;

    assign retry_in = WR_DATA[5:3];
    // invalid retry code is refused whole
    assign bad_data = (retry_in != `RETRY_OFF) && (retry_in != `RETRY_ALWAYS);
    // page 1 addresses a slave channel when channel two is not master
    assign bad_page = (PAGE == `PAGE_CH2) && !CH2_MASTER;
    assign wr_ch1   = WR_STROBE && !bad_data
                      && (PAGE == `PAGE_CH1 || PAGE == `PAGE_BOTH);
    assign wr_ch2   = WR_STROBE && !bad_data && CH2_MASTER
                      && (PAGE == `PAGE_CH2 || PAGE == `PAGE_BOTH);
    // a slave channel two follows channel one's setting
    assign retry2_eff = CH2_MASTER ? retry2_q : retry1_q;

    always_comb begin
        retry1_d  = wr_ch1 ? retry_in : retry1_q;
        retry2_d  = wr_ch2 ? retry_in : retry2_q;
        nack_d    = WR_STROBE && (bad_page || bad_data);
        rd_data_d = RD_DATA;
        if (RD_STROBE) begin
            // reserved high bits read zero, low bits read ones
            rd_data_d = {2'h0, ((PAGE == `PAGE_CH2) ? retry2_eff : retry1_q),
                         `RESP_RO_LOW};
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            retry1_q <= 3'(`RESP_RESET >> 3);
            retry2_q <= 3'(`RESP_RESET >> 3);
            RD_DATA  <= `RESP_RESET;
            WR_NACK  <= 1'b0;
        end else begin
            retry1_q <= retry1_d;
            retry2_q <= retry2_d;
            RD_DATA  <= rd_data_d;
            WR_NACK  <= nack_d;
        end
    end

    // ----------------------------------------
    // channel sequencers
    // ----------------------------------------
    logic [1:0] en_w, ss_w, oc_w;

    ocfr_channel u_ch1 (
        .clk           (CORE_CLK),
        .rst_b         (RST_B),
        .retry_setting (retry1_q),
        .oc_event      (oc_rise[0]),
        .uv_event      (uv_rise[0]),
        .cmd_on        (pins_sync_q[0]),
        .bias_ok       (bias_sync_q[1]),
        .other_fault   (OTHER_FAULT[0]),
        .fault_clear   (bias_sync_q[0]),
        .ss_done       (SS_DONE[0]),
        .enable_q      (en_w[0]),
        .soft_start_q  (ss_w[0]),
        .oc_pulse      (oc_w[0])
    );

    ocfr_channel u_ch2 (
        .clk           (CORE_CLK),
        .rst_b         (RST_B),
        .retry_setting (retry2_eff),
        .oc_event      (oc_rise[1]),
        .uv_event      (uv_rise[1]),
        .cmd_on        (pins_sync_q[1]),
        .bias_ok       (bias_sync_q[1]),
        .other_fault   (OTHER_FAULT[1]),
        .fault_clear   (bias_sync_q[0]),
        .ss_done       (SS_DONE[1]),
        .enable_q      (en_w[1]),
        .soft_start_q  (ss_w[1]),
        .oc_pulse      (oc_w[1])
    );

    // ----------------------------------------
    // status flags and alert
    // ----------------------------------------
    ocfr_pkg::status_t st1_q, st1_d, st2_q, st2_d;
    logic              alert_d;
    logic              cml_ev, inv_cmd_ev;

    assign cml_ev     = WR_STROBE && bad_data;
    // a slave page write reports invalid command even when its data is bad too
    assign inv_cmd_ev = WR_STROBE && bad_page;

    // set wins over clear, so an event in the clear cycle survives
    function automatic ocfr_pkg::status_t upd(input ocfr_pkg::status_t s,
                                              input logic oc,
                                              input logic cml,
                                              input logic bad_cmd,
                                              input logic clr);
        ocfr_pkg::status_t r;
        r = clr ? '0 : s;
        if (oc) begin
            r.summary    = 1'b1;
            r.oc_fault   = 1'b1;
            r.iout_fault = 1'b1;
            r.iout_warn  = 1'b1;
            r.byte_oc    = 1'b1;
        end
        if (cml) begin
            r.cml = 1'b1;
            r.ivd = 1'b1;
        end
        if (bad_cmd) begin
            r.invalid_command_fault = 1'b1;
        end
        return r;
    endfunction : upd

    always_comb begin
        st1_d   = upd(st1_q, oc_w[0], cml_ev, inv_cmd_ev, bias_sync_q[0]);
        st2_d   = upd(st2_q, oc_w[1], 1'b0, 1'b0, bias_sync_q[0]);
        // alert stays low while any flag is pending
        alert_d = !((|st1_d) || (|st2_d));
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            st1_q        <= '0;
            st2_q        <= '0;
            ALERT_LINE_B <= 1'b1;
            CH1_STATUS   <= '0;
            CH2_STATUS   <= '0;
            OUT_ENABLE   <= '0;
            SOFT_START   <= '0;
        end else begin
            st1_q        <= st1_d;
            st2_q        <= st2_d;
            ALERT_LINE_B <= alert_d;
            CH1_STATUS   <= st1_d;
            CH2_STATUS   <= st2_d;
            OUT_ENABLE   <= en_w;
            SOFT_START   <= ss_w;
        end
    end
endmodule : overcurrent_fault_response

// *** ocfr_defines.svh ***
// constants for the over-current fault response block
`ifndef OCFR_DEFINES_SVH
`define OCFR_DEFINES_SVH
`define RESP_RESET      8'h07
`define RESP_RO_LOW     3'h7
`define RETRY_OFF       3'h0
`define RETRY_ALWAYS    3'h7
`define PAGE_CH1        2'h0
`define PAGE_CH2        2'h1
`define PAGE_BOTH       2'h3
`define SS_UNIT_NS      1000
`define CLK_PERIOD_NS   5
`define SS_UNIT_CYC     ((`SS_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RETRY_UNITS     8'h07
`define CYC_W           16
`endif

// *** ocfr_pkg.sv ***
// types for the over-current fault response block
package ocfr_pkg;
    typedef struct packed {
        logic summary;
        logic oc_fault;
        logic iout_fault;
        logic iout_warn;
        logic byte_oc;
        logic cml;
        logic ivd;
        logic invalid_command_fault;
    } status_t;
    typedef enum logic [1:0] {
        CH_RUN,
        CH_OFF,
        CH_WAIT,
        CH_SOFT
    } ch_state_t;
endpackage : ocfr_pkg

// *** ocfr_channel.sv ***
// per-channel fault response sequencer and over-current pulse
`include "ocfr_defines.svh"
module ocfr_channel (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] retry_setting,
    input  wire logic       oc_event,
    input  wire logic       uv_event,
    input  wire logic       cmd_on,
    input  wire logic       bias_ok,
    input  wire logic       other_fault,
    input  wire logic       fault_clear,
    input  wire logic       ss_done,
    output logic            enable_q,
    output logic            soft_start_q,
    output logic            oc_pulse
);
    // ----------------------------------------
    // retry sequencer
    // ----------------------------------------
    ocfr_pkg::ch_state_t    state_q, state_d;
    logic [`CYC_W-1:0]      cyc_q, cyc_d;
    logic [7:0]             units_q, units_d;
    logic                   enable_d;
    logic                   soft_start_d;
    logic                   stop;

    assign oc_pulse = oc_event;
    assign stop     = !cmd_on || !bias_ok || other_fault;

    always_comb begin
        state_d      = state_q;
        cyc_d        = cyc_q;
        units_d      = units_q;
        case (state_q)
            ocfr_pkg::CH_RUN: begin
                if (stop) begin
                    state_d = ocfr_pkg::CH_OFF;
                end else if (oc_event || uv_event) begin
                    cyc_d   = '0;
                    units_d = '0;
                    // latch off or retry forever
                    state_d = (retry_setting == `RETRY_ALWAYS) ? ocfr_pkg::CH_WAIT
                                                               : ocfr_pkg::CH_OFF;
                end
            end
            ocfr_pkg::CH_OFF: begin
                // restart only after clear with command on and bias present
                if (fault_clear && !stop) begin
                    state_d = ocfr_pkg::CH_SOFT;
                end
            end
            ocfr_pkg::CH_WAIT: begin
                if (stop) begin
                    state_d = ocfr_pkg::CH_OFF;
                end else if (cyc_q == `CYC_W'(`SS_UNIT_CYC - 1)) begin
                    cyc_d   = '0;
                    units_d = units_q + 8'h01;
                    // delay of seven soft-start units, fixed by the low bits
                    if (units_q == `RETRY_UNITS - 8'h01) begin
                        state_d = ocfr_pkg::CH_SOFT;
                    end
                end else begin
                    cyc_d = cyc_q + `CYC_W'(1);
                end
            end
            ocfr_pkg::CH_SOFT: begin
                if (stop) begin
                    state_d = ocfr_pkg::CH_OFF;
                end else if (oc_event || uv_event) begin
                    cyc_d   = '0;
                    units_d = '0;
                    state_d = (retry_setting == `RETRY_ALWAYS) ? ocfr_pkg::CH_WAIT
                                                               : ocfr_pkg::CH_OFF;
                end else if (ss_done) begin
                    state_d = ocfr_pkg::CH_RUN;
                end
            end
            default: state_d = ocfr_pkg::CH_OFF;
        endcase
        enable_d     = (state_d == ocfr_pkg::CH_RUN) || (state_d == ocfr_pkg::CH_SOFT);
        soft_start_d = (state_d == ocfr_pkg::CH_SOFT);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q      <= ocfr_pkg::CH_OFF;
            cyc_q        <= '0;
            units_q      <= '0;
            enable_q     <= 1'b0;
            soft_start_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            cyc_q        <= cyc_d;
            units_q      <= units_d;
            enable_q     <= enable_d;
            soft_start_q <= soft_start_d;
        end
    end
endmodule : ocfr_channel

// *** ocfr_sva.sv ***
// checker of the over-current fault response block ports
module ocfr_sva (
    input wire logic       CORE_CLK,
    input wire logic       RST_B,
    input wire logic       WR_STROBE,
    input wire logic       RD_STROBE,
    input wire logic [1:0] PAGE,
    input wire logic [7:0] WR_DATA,
    input wire logic       CH2_MASTER,
    input wire logic [7:0] RD_DATA,
    input wire logic       WR_NACK,
    input wire logic       ALERT_LINE_B,
    input wire logic [7:0] CH1_STATUS,
    input wire logic [1:0] OUT_ENABLE
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------------------
    // properties
    // --------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    logic       good;
    logic [2:0] retry_q;
    assign good = WR_DATA[5:3] == 3'h0 || WR_DATA[5:3] == 3'h7;
    // shadow of channel one retry; refused writes leave it alone
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            retry_q <= 3'h0;
        end else if (WR_STROBE && good && PAGE[1] == PAGE[0]) begin
            retry_q <= WR_DATA[5:3];
        end
    end
    sequence oc_hit;
        $rose(CH1_STATUS[6]);
    endsequence
    sequence held_off;
        ##3 (!OUT_ENABLE[0]) [*8];
    endsequence
    rst_value_a: assert property ($rose(RST_B) |-> RD_DATA == 8'h07)
        else $error("bad reset value");
    read_back_a: assert property (
        RD_STROBE && !PAGE |=> RD_DATA == {2'h0, retry_q, 3'h7}) else $error("bad read value");
    oc_flags_a: assert property (oc_hit |-> CH1_STATUS[7:3] == 5'h1f)
        else $error("fault flags incomplete");
    oc_alert_a: assert property (oc_hit |-> ##1 !ALERT_LINE_B)
        else $error("no alert on fault");
    slave_nack_a: assert property (
        WR_STROBE && PAGE == 2'h1 && !CH2_MASTER |=> WR_NACK && CH1_STATUS[0] ##1 !ALERT_LINE_B)
        else $error("slave write not refused");
    bad_retry_a: assert property (
        WR_STROBE && !good && PAGE != 2'h1 |=> WR_NACK && CH1_STATUS[2:1] == 2'h3 ##1 !ALERT_LINE_B)
        else $error("bad retry accepted");
    page_ok_a: assert property (
        WR_STROBE && good && (PAGE[1] == PAGE[0] || PAGE == 2'h1 && CH2_MASTER) |=> !WR_NACK)
        else $error("good write refused");
    latch_off_a: assert property (oc_hit ##0 retry_q == 3'h0 |-> held_off)
        else $error("restart with retry off");
endmodule : ocfr_sva
bind overcurrent_fault_response ocfr_sva i_sva (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE),
    .PAGE(PAGE), .WR_DATA(WR_DATA), .CH2_MASTER(CH2_MASTER), .RD_DATA(RD_DATA),
    .WR_NACK(WR_NACK), .ALERT_LINE_B(ALERT_LINE_B), .CH1_STATUS(CH1_STATUS),
    .OUT_ENABLE(OUT_ENABLE)
);

// *** ocfr_host.sv ***
// host model driving the paged register port
module ocfr_host (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       wr_nack,
    output logic            wr_stb  = 1'b0,
    output logic            rd_stb  = 1'b0,
    output logic [1:0]      page    = 2'h2,
    output logic [7:0]      wr_data = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------------------
    // one access per call
    // --------------------
    // a slave page follows its master inside the block, not by the host
    task automatic acc(input logic w, input logic [1:0] p, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk);
        page    = p;
        wr_data = d;
        wr_stb  = w;
        rd_stb  = !w;
        @(negedge clk);
        q       = {7'h0, wr_nack};
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        // released lines must not show a stale value
        page    = ~p;
        wr_data = ~d;
        @(negedge clk);
        if (!w) begin
            q = rd_data;
        end
    endtask : acc
endmodule : ocfr_host

// *** overcurrent_fault_response_tb_top.sv ***
// self-checking testbench of the over-current fault response block
module overcurrent_fault_response_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // --------------------
    // harness and tests
    // --------------------
    logic       clk = 1'b0, rst_b = 1'b0, ch2_mst = 1'b0, clr_in = 1'b0;
    logic       wr_stb, rd_stb, nack, alert_b;
    logic [1:0] oc_in = 2'h0, cmd_on = 2'h0, page, oe;
    logic [1:0] uv_in = 2'h0, oth = 2'h0, ss_done = 2'h3, ss;
    logic [7:0] wr_data, rd_data, st1, st2;
    int         n_mismatch = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    overcurrent_fault_response i_dut (
        .CORE_CLK(clk), .RST_B(rst_b), .WR_STROBE(wr_stb), .RD_STROBE(rd_stb), .PAGE(page),
        .WR_DATA(wr_data), .CH2_MASTER(ch2_mst), .OC_FAULT_IN(oc_in), .UV_FAULT_IN(uv_in),
        .CMD_ON(cmd_on), .BIAS_OK(1'b1), .OTHER_FAULT(oth), .SS_DONE(ss_done),
        .CLEAR_FAULTS(clr_in), .RD_DATA(rd_data), .WR_NACK(nack), .ALERT_LINE_B(alert_b),
        .CH1_STATUS(st1), .CH2_STATUS(st2), .OUT_ENABLE(oe), .SOFT_START(ss));
    ocfr_host i_host (.clk(clk), .rd_data(rd_data), .wr_nack(nack), .wr_stb(wr_stb),
                      .rd_stb(rd_stb), .page(page), .wr_data(wr_data));
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic ac(input logic w, input logic [1:0] p, input logic [7:0] d, e);
        logic [7:0] q;
        i_host.acc(w, p, d, q);
        chk(w ? "refusal" : "read data", e, q);
    endtask : ac
    task automatic clr();
        clr_in = 1'b1;
        repeat (4) @(negedge clk);
        clr_in = 1'b0;
        repeat (8) @(negedge clk);
    endtask : clr
    // bounded wait for an output to come up; the retry wait is long
    task automatic go(input int c, output int n);
        for (n = 0; oe[c] !== 1'b1 && n < 3000; n++) begin
            @(negedge clk);
        end
    endtask : go
    initial begin
        int n;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        ac(1'b0, 2'h0, 8'h00, 8'h07);
        chk("alert", 8'h01, {7'h0, alert_b});
        ac(1'b1, 2'h0, 8'hff, 8'h00);
        ac(1'b0, 2'h0, 8'h00, 8'h3f);
        for (int v = 1; v < 7; v++) begin
            ac(1'b1, 2'h0, 8'(v * 8), 8'h01);
        end
        ac(1'b0, 2'h0, 8'h00, 8'h3f);
        chk("comm flags", 8'h06, st1);
        clr();
        ac(1'b1, 2'h1, 8'h38, 8'h01);
        chk("invalid command flag", 8'h01, st1);
        ac(1'b1, 2'h3, 8'h00, 8'h00);
        ac(1'b0, 2'h1, 8'h00, 8'h07);
        clr();
        ch2_mst = 1'b1;
        ac(1'b1, 2'h1, 8'h38, 8'h00);
        ac(1'b0, 2'h1, 8'h00, 8'h3f);
        ac(1'b0, 2'h0, 8'h00, 8'h07);
        cmd_on = 2'h3;
        clr();
        go(0, n);
        go(1, n);
        oc_in = 2'h1;
        repeat (6) @(negedge clk);
        chk("ch1 status", 8'hf8, st1);
        chk("ch2 status", 8'h00, st2);
        chk("alert", 8'h00, {7'h0, alert_b});
        oc_in = 2'h2;
        repeat (6) @(negedge clk);
        chk("ch2 status", 8'hf8, st2);
        chk("outputs", 8'h00, {6'h0, oe});
        // hold soft start open so the restart phase can be seen
        ss_done = 2'h0;
        go(1, n);
        chk("retry wait", 8'h01, {7'h0, n > 1300 && n < 1700});
        chk("ch1 held off", 8'h02, {6'h0, oe});
        chk("soft start", 8'h02, {6'h0, ss});
        ss_done = 2'h3;
        clr();
        go(0, n);
        chk("released", 8'h03, {6'h0, oe});
        chk("soft start", 8'h00, {6'h0, ss});
        // under-voltage takes the same response path
        oc_in = 2'h0;
        repeat (4) @(negedge clk);
        uv_in = 2'h3;
        repeat (6) @(negedge clk);
        chk("uv response", 8'h00, {6'h0, oe});
        // another shutdown fault ends the endless retry
        oth = 2'h2;
        repeat (1600) @(negedge clk);
        chk("retry stopped", 8'h00, {6'h0, oe});
        summarize();
    end
    initial begin
        #300000;
        n_mismatch++;
        summarize();
    end
endmodule : overcurrent_fault_response_tb_top
